// file: core/fpm_axil.sv
`include "fpm_defs.svh"
module fpm_axil (
  input  wire logic              sys_clk,        // System clock
  input  wire logic              sys_rst,        // Synchronous reset
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire fpm_pkg::fpm_addr_t s_axi_awaddr,  // Write address
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  input  wire fpm_pkg::fpm_data_t s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Byte enables
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  output logic [1:0]             s_axi_bresp,    // Write response
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  input  wire fpm_pkg::fpm_addr_t s_axi_araddr,  // Read address
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready,   // Read data ready
  output fpm_pkg::fpm_data_t     s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   wr_en,          // Write pulse to regs
  output fpm_pkg::fpm_addr_t     wr_addr,        // Write address
  output fpm_pkg::fpm_data_t     wr_data,        // Write data
  output logic [3:0]             wr_strb,        // Write byte enables
  input  wire logic              wr_err,         // Write address unmapped
  output logic                   rd_en,          // Read pulse to regs
  output fpm_pkg::fpm_addr_t     rd_addr,        // Read address
  input  wire fpm_pkg::fpm_data_t rd_data,       // Read value
  input  wire logic              rd_err          // Read address unmapped
);
  import fpm_pkg::*;

  logic      aw_q, aw_d;      // Address held, waiting for data
  logic      w_q, w_d;        // Data held, waiting for address
  fpm_addr_t awa_q, awa_d;    // Held write address
  fpm_data_t wd_q, wd_d;      // Held write data
  logic [3:0] ws_q, ws_d;     // Held byte enables
  logic      bv_q, bv_d;      // Write response pending
  logic [1:0] br_q, br_d;     // Write response code
  logic      rv_q, rv_d;      // Read response pending
  fpm_data_t rd_q, rd_d;      // Read data captured
  logic [1:0] rr_q, rr_d;     // Read response code

  // Each channel is refused while its slot is full; address and data also while a write response is pending
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign rd_en         = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr;

  // Address and data may arrive in either order; write fires on both
  always_comb
  begin
    aw_d    = aw_q;
    w_d     = w_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bv_d    = bv_q;
    br_d    = br_q;
    rv_d    = rv_q;
    rd_d    = rd_q;
    rr_d    = rr_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    wr_en   = aw_d && w_d && !bv_q;
    wr_addr = awa_d;
    wr_data = wd_d;
    wr_strb = ws_d;
    if (wr_en)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = wr_err ? `FPM_RESP_SLVERR : `FPM_RESP_OKAY;
    end
    else if (bv_q && s_axi_bready)
    begin
      bv_d = 1'b0;
    end
    // Read data is sampled the cycle the address is taken
    if (rd_en)
    begin
      rv_d = 1'b1;
      rd_d = rd_data;
      rr_d = rd_err ? `FPM_RESP_SLVERR : `FPM_RESP_OKAY;
    end
    else if (rv_q && s_axi_rready)
    begin
      rv_d = 1'b0;
    end
  end

  // Channel state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= '0;
      wd_q  <= '0;
      ws_q  <= '0;
      bv_q  <= 1'b0;
      br_q  <= `FPM_RESP_OKAY;
      rv_q  <= 1'b0;
      rd_q  <= '0;
      rr_q  <= `FPM_RESP_OKAY;
    end
    else
    begin
      aw_q  <= aw_d;
      w_q   <= w_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
    end
  end

endmodule : fpm_axil

// file: core/fpm_defs.svh
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// Bus widths
`define FPM_AW            8
`define FPM_DW            32
`define FPM_BYTE_W        8

// Register byte offsets
`define FPM_OFS_CFG       8'h00
`define FPM_OFS_DRV       8'h04
`define FPM_OFS_DATA      8'h08
`define FPM_OFS_STAT      8'h0c
`define FPM_OFS_CTRL      8'h10
`define FPM_OFS_STATE     8'h14

// Configuration register fields
`define FPM_CFG_PWR       0
`define FPM_CFG_SEL_LO    1
`define FPM_CFG_SEL_HI    2
`define FPM_CFG_ECP       3
`define FPM_CFG_DMA_OK    4
`define FPM_CFG_IRQ_LOW   5
`define FPM_CFG_W         6
`define FPM_CFG_RST       6'h00

// Printer control register fields
`define FPM_CTL_STROBE    0
`define FPM_CTL_AUTOFD    1
`define FPM_CTL_INIT      2
`define FPM_CTL_SELIN     3
`define FPM_CTL_DIR       5
`define FPM_CTL_W         6
`define FPM_CTL_RST       6'h04
`define FPM_CTL_LOW_W     4
`define FPM_CTL_CABLE_OFF 4'h4

// Printer status register fields
`define FPM_ST_ERR        3
`define FPM_ST_SLCT       4
`define FPM_ST_PE         5
`define FPM_ST_ACK        6
`define FPM_ST_BUSY       7
`define FPM_ST_FORCED     8'h48

// Mux state read-only register fields
`define FPM_MS_ON         0
`define FPM_MS_DUAL       1
`define FPM_MS_PORT_ON    2
`define FPM_MS_NAT_OFF    3

// Connector control and status pin indices
`define FPM_PC_W          9
`define FPM_PC_STB        0
`define FPM_PC_AFD        1
`define FPM_PC_INIT       2
`define FPM_PC_SLIN       3
`define FPM_PC_ACK        4
`define FPM_PC_BUSY       5
`define FPM_PC_PE         6
`define FPM_PC_SLCT       7
`define FPM_PC_ERR        8

// Native floppy output indices
`define FPM_NO_W          10
`define FPM_NO_WDATA      0
`define FPM_NO_DENS       1
`define FPM_NO_HEAD       2
`define FPM_NO_WGATE      3
`define FPM_NO_DIR        4
`define FPM_NO_STEP       5
`define FPM_NO_DS0        6
`define FPM_NO_DS1        7
`define FPM_NO_MTR0       8
`define FPM_NO_MTR1       9

// Drive inputs, carried on data lines 0 to 4 in floppy mode
`define FPM_NI_W          5
`define FPM_PD_MTR0       6

// AXI responses
`define FPM_RESP_OKAY     2'b00
`define FPM_RESP_SLVERR   2'b10

`endif

// file: core/fpm_pkg.sv
`include "fpm_defs.svh"

package fpm_pkg;

  // Port routing mode, decoded from the two select bits
  typedef enum logic [1:0] {
    FPM_NORMAL = 2'b00,
    FPM_SINGLE = 2'b01,
    FPM_DUAL   = 2'b10
  } fpm_mode_e;

  typedef logic [`FPM_AW-1:0]    fpm_addr_t;
  typedef logic [`FPM_DW-1:0]    fpm_data_t;
  typedef logic [`FPM_BYTE_W-1:0] fpm_byte_t;

endpackage : fpm_pkg

// file: core/fpm_sync.sv
module fpm_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         sys_rst,  // Synchronous reset
  input  wire logic [W-1:0] async_i,  // Level from a pin
  output logic      [W-1:0] sync_o    // Level safe to use
);
  import fpm_pkg::*;

  logic [W-1:0] meta_q;  // First stage, read only by the second

  // One two-flop chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule : fpm_sync

// file: core/fpm_top.sv
// Functional notes
// - Single mode: drive 1 on port, drive 0 native
// - Dual mode: both drives on port
// - Printer unavailable while any floppy mode selected
// - Port DMA: low only if ECP and allowed
// - Port interrupt held inactive, low or floating
// - Data read returns last written value
// - Control read shows cable not connected
// - Status read returns fixed values
// - Native outputs float when port drive selected
// - Drive inputs taken from data lines 0-4
// - Status and control pins carry floppy outputs
// - Strobe and data 6: outputs dual, inputs single
// - Port floppy ignores printer power bit
// - Select bits decide mux; else power bit rules
`include "fpm_defs.svh"
module fpm_top (
  input  wire logic                    sys_clk,        // System clock, 25 MHz
  input  wire logic                    sys_rst,        // Synchronous reset, high
  input  wire logic                    s_axi_awvalid,  // Write address valid
  output logic                         s_axi_awready,  // Write address ready
  input  wire fpm_pkg::fpm_addr_t      s_axi_awaddr,   // Write address
  input  wire logic                    s_axi_wvalid,   // Write data valid
  output logic                         s_axi_wready,   // Write data ready
  input  wire fpm_pkg::fpm_data_t      s_axi_wdata,    // Write data
  input  wire logic [3:0]              s_axi_wstrb,    // Byte enables
  output logic                         s_axi_bvalid,   // Write response valid
  input  wire logic                    s_axi_bready,   // Write response ready
  output logic [1:0]                   s_axi_bresp,    // Write response
  input  wire logic                    s_axi_arvalid,  // Read address valid
  output logic                         s_axi_arready,  // Read address ready
  input  wire fpm_pkg::fpm_addr_t      s_axi_araddr,   // Read address
  output logic                         s_axi_rvalid,   // Read data valid
  input  wire logic                    s_axi_rready,   // Read data ready
  output fpm_pkg::fpm_data_t           s_axi_rdata,    // Read data
  output logic [1:0]                   s_axi_rresp,    // Read response
  input  wire logic [`FPM_NO_W-1:0]    fdc_out,        // Floppy core outputs
  input  wire logic                    fdc_drv_sel,    // Core selects drive 1
  output logic [`FPM_NI_W-1:0]         fdc_in,         // Drive inputs to core
  input  wire logic                    pp_dma_req,     // Printer core DMA request
  input  wire logic                    pp_irq,         // Printer core interrupt
  output logic [`FPM_NO_W-1:0]         nat_out,        // Native floppy pins out
  output logic [`FPM_NO_W-1:0]         nat_oe_n,       // Native pins enable, low
  input  wire logic [`FPM_NI_W-1:0]    nat_in,         // Native drive input pins
  input  wire logic [`FPM_BYTE_W-1:0]  pd_in,          // Connector data pins in
  output logic [`FPM_BYTE_W-1:0]       pd_out,         // Connector data pins out
  output logic [`FPM_BYTE_W-1:0]       pd_oe_n,        // Data pins enable, low
  input  wire logic [`FPM_PC_W-1:0]    pc_in,          // Control/status pins in
  output logic [`FPM_PC_W-1:0]         pc_out,         // Control/status pins out
  output logic [`FPM_PC_W-1:0]         pc_oe_n,        // Control/status enable
  output logic                         port_dma_request, // Port DMA pin out
  output logic                         port_dma_oe_n,    // Port DMA enable, low
  output logic                         port_irq_out,     // Port interrupt pin out
  output logic                         port_irq_oe_n     // Interrupt enable, low
);
  import fpm_pkg::*;

  // Bus side signals
  logic      wr_en;           // Register write pulse
  fpm_addr_t wr_addr;         // Register write address
  fpm_data_t wr_data;         // Register write data
  logic [3:0] wr_strb;        // Register write lanes
  logic      wr_err;          // Unmapped write
  logic      rd_en;           // Register read pulse
  fpm_addr_t rd_addr;         // Register read address
  fpm_data_t rd_data;         // Register read value
  logic      rd_err;          // Unmapped read

  // Synchronised pins
  logic [`FPM_BYTE_W-1:0] pd_s;   // Data pins
  logic [`FPM_PC_W-1:0]   pc_s;   // Control and status pins
  logic [`FPM_NI_W-1:0]   nat_s;  // Native drive inputs

  // Software state
  logic [`FPM_CFG_W-1:0]  cfg_q, cfg_d;    // Mode and port configuration
  logic                   drv_q, drv_d;    // Software view of drive select
  fpm_byte_t              data_q, data_d;  // Printer data latch
  logic [`FPM_CTL_W-1:0]  ctl_q, ctl_d;    // Printer control latch

  // Decoded mode
  fpm_mode_e mode;       // Current routing mode
  logic      mux_on;     // Floppy on the connector
  logic      dual;       // Both drives on the connector
  logic      port_on;    // Printer function live
  logic      on_port;    // Selected drive sits on the connector
  logic      lane0;      // Low byte written

  // Registered pin drive
  logic [`FPM_NO_W-1:0]   nat_out_q, nat_out_d, nat_oe_q, nat_oe_d;
  logic [`FPM_NI_W-1:0]   fin_q, fin_d;
  logic [`FPM_BYTE_W-1:0] pdo_q, pdo_d, pdoe_q, pdoe_d;
  logic [`FPM_PC_W-1:0]   pco_q, pco_d, pcoe_q, pcoe_d;
  logic                   dma_q, dma_d, dmaoe_q, dmaoe_d;
  logic                   irq_q, irq_d, irqoe_q, irqoe_d;

  // Register bus slave
  fpm_axil u_axil (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Pins come from the cable, outside our clock
  fpm_sync #(.W(`FPM_BYTE_W)) u_sync_pd (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .async_i (pd_in),
    .sync_o  (pd_s)
  );
  fpm_sync #(.W(`FPM_PC_W)) u_sync_pc (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .async_i (pc_in),
    .sync_o  (pc_s)
  );
  fpm_sync #(.W(`FPM_NI_W)) u_sync_nat (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .async_i (nat_in),
    .sync_o  (nat_s)
  );

  // Mode decode straight from the stored bits, no command needed
  always_comb
  begin
    case ({cfg_q[`FPM_CFG_SEL_HI], cfg_q[`FPM_CFG_SEL_LO]})
      2'b00:   mode = FPM_NORMAL;
      2'b01:   mode = FPM_SINGLE;
      default: mode = FPM_DUAL;   // High bit alone or both: dual
    endcase
  end

  assign mux_on  = (mode != FPM_NORMAL);
  assign dual    = (mode == FPM_DUAL);
  // Power bit only matters when no floppy mode is chosen
  assign port_on = !mux_on && cfg_q[`FPM_CFG_PWR];
  // Single mode puts only drive 1 on the cable
  assign on_port = dual || (mode == FPM_SINGLE && fdc_drv_sel);
  assign lane0   = wr_strb[0];

  // Address decode for writes
  always_comb
  begin
    wr_err = 1'b1;
    case (wr_addr)
      `FPM_OFS_CFG, `FPM_OFS_DRV, `FPM_OFS_DATA, `FPM_OFS_CTRL: wr_err = 1'b0;
      default: wr_err = 1'b1;   // Status and state are read only
    endcase
  end

  // Register writes; unmapped or unlaned writes leave state alone
  always_comb
  begin
    cfg_d  = cfg_q;
    drv_d  = drv_q;
    data_d = data_q;
    ctl_d  = ctl_q;
    if (wr_en && !wr_err && lane0)
    begin
      case (wr_addr)
        `FPM_OFS_CFG:  cfg_d  = wr_data[`FPM_CFG_W-1:0];
        `FPM_OFS_DRV:  drv_d  = wr_data[0];
        `FPM_OFS_DATA: data_d = wr_data[`FPM_BYTE_W-1:0];  // Kept in every mode
        `FPM_OFS_CTRL: ctl_d  = wr_data[`FPM_CTL_W-1:0];
        default:       cfg_d  = cfg_q;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cfg_q  <= `FPM_CFG_RST;
      drv_q  <= 1'b0;
      data_q <= '0;
      ctl_q  <= `FPM_CTL_RST;
    end
    else
    begin
      cfg_q  <= cfg_d;
      drv_q  <= drv_d;
      data_q <= data_d;
      ctl_q  <= ctl_d;
    end
  end

  // Read mux; in floppy mode the printer registers show a dead cable
  always_comb
  begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (rd_addr)
      `FPM_OFS_CFG: rd_data[`FPM_CFG_W-1:0] = cfg_q;
      `FPM_OFS_DRV:
      begin
        rd_data[0] = drv_q;
        rd_data[1] = fdc_drv_sel;   // Live drive select from the core
      end
      `FPM_OFS_DATA:
      begin
        if (mux_on)
          rd_data[`FPM_BYTE_W-1:0] = data_q;
        else
          rd_data[`FPM_BYTE_W-1:0] = pd_s;
      end
      `FPM_OFS_STAT:
      begin
        if (mux_on)
          rd_data[`FPM_BYTE_W-1:0] = `FPM_ST_FORCED;
        else
        begin
          rd_data[`FPM_ST_BUSY] = !pc_s[`FPM_PC_BUSY];
          rd_data[`FPM_ST_ACK]  = pc_s[`FPM_PC_ACK];
          rd_data[`FPM_ST_PE]   = pc_s[`FPM_PC_PE];
          rd_data[`FPM_ST_SLCT] = pc_s[`FPM_PC_SLCT];
          rd_data[`FPM_ST_ERR]  = pc_s[`FPM_PC_ERR];
        end
      end
      `FPM_OFS_CTRL:
      begin
        rd_data[`FPM_CTL_W-1:0] = ctl_q;
        if (mux_on)
          rd_data[`FPM_CTL_LOW_W-1:0] = `FPM_CTL_CABLE_OFF;
      end
      `FPM_OFS_STATE:
      begin
        rd_data[`FPM_MS_ON]      = mux_on;
        rd_data[`FPM_MS_DUAL]    = dual;
        rd_data[`FPM_MS_PORT_ON] = port_on;
        rd_data[`FPM_MS_NAT_OFF] = mux_on && on_port;
      end
      default: rd_err = 1'b1;   // Unmapped: zero data, error response
    endcase
  end

  // Pin routing; every pin floats unless a function owns it
  always_comb
  begin
    nat_out_d = fdc_out;
    nat_oe_d  = '0;
    fin_d     = nat_s;
    pdo_d     = data_q;
    pdoe_d    = '1;
    pco_d     = '0;
    pcoe_d    = '1;
    dma_d     = 1'b0;
    dmaoe_d   = 1'b1;
    irq_d     = 1'b0;
    irqoe_d   = 1'b1;
    if (mux_on)
    begin
      // Cable power is irrelevant here, so the power bit is not looked at
      if (on_port)
      begin
        nat_oe_d = '1;
        fin_d    = pd_s[`FPM_NI_W-1:0];
      end
      pco_d[`FPM_PC_ACK]  = fdc_out[`FPM_NO_DS1];
      pco_d[`FPM_PC_BUSY] = fdc_out[`FPM_NO_MTR1];
      pco_d[`FPM_PC_PE]   = fdc_out[`FPM_NO_WDATA];
      pco_d[`FPM_PC_SLCT] = fdc_out[`FPM_NO_WGATE];
      pco_d[`FPM_PC_AFD]  = fdc_out[`FPM_NO_DENS];
      pco_d[`FPM_PC_ERR]  = fdc_out[`FPM_NO_HEAD];
      pco_d[`FPM_PC_INIT] = fdc_out[`FPM_NO_DIR];
      pco_d[`FPM_PC_SLIN] = fdc_out[`FPM_NO_STEP];
      pcoe_d              = '0;
      // Drive 0 lines only drive in dual mode; single leaves them as inputs
      pco_d[`FPM_PC_STB]  = fdc_out[`FPM_NO_DS0];
      pcoe_d[`FPM_PC_STB] = !dual;
      pdo_d               = '0;
      pdo_d[`FPM_PD_MTR0] = fdc_out[`FPM_NO_MTR0];
      pdoe_d[`FPM_PD_MTR0] = !dual;
      // DMA request pulled low only for ECP with DMA allowed
      if (cfg_q[`FPM_CFG_ECP] && cfg_q[`FPM_CFG_DMA_OK])
        dmaoe_d = 1'b0;
      // Interrupt never asserts; low or floating by setting
      irqoe_d = !cfg_q[`FPM_CFG_IRQ_LOW];
    end
    else if (port_on)
    begin
      // Plain printer port; pin levels invert the latched control bits, except init which passes straight
      pdoe_d              = {`FPM_BYTE_W{ctl_q[`FPM_CTL_DIR]}};
      pco_d[`FPM_PC_STB]  = !ctl_q[`FPM_CTL_STROBE];
      pco_d[`FPM_PC_AFD]  = !ctl_q[`FPM_CTL_AUTOFD];
      pco_d[`FPM_PC_INIT] = ctl_q[`FPM_CTL_INIT];
      pco_d[`FPM_PC_SLIN] = !ctl_q[`FPM_CTL_SELIN];
      pcoe_d[`FPM_PC_SLIN:`FPM_PC_STB] = '0;
      dma_d   = pp_dma_req;
      dmaoe_d = 1'b0;
      irq_d   = pp_irq;
      irqoe_d = 1'b0;
    end
  end

  // Pin drive registers; one cycle from configuration to pins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      nat_out_q <= '0;
      nat_oe_q  <= '0;
      fin_q     <= '0;
      pdo_q     <= '0;
      pdoe_q    <= '1;
      pco_q     <= '0;
      pcoe_q    <= '1;
      dma_q     <= 1'b0;
      dmaoe_q   <= 1'b1;
      irq_q     <= 1'b0;
      irqoe_q   <= 1'b1;
    end
    else
    begin
      nat_out_q <= nat_out_d;
      nat_oe_q  <= nat_oe_d;
      fin_q     <= fin_d;
      pdo_q     <= pdo_d;
      pdoe_q    <= pdoe_d;
      pco_q     <= pco_d;
      pcoe_q    <= pcoe_d;
      dma_q     <= dma_d;
      dmaoe_q   <= dmaoe_d;
      irq_q     <= irq_d;
      irqoe_q   <= irqoe_d;
    end
  end

  assign nat_out          = nat_out_q;
  assign nat_oe_n         = nat_oe_q;
  assign fdc_in           = fin_q;
  assign pd_out           = pdo_q;
  assign pd_oe_n          = pdoe_q;
  assign pc_out           = pco_q;
  assign pc_oe_n          = pcoe_q;
  assign port_dma_request = dma_q;
  assign port_dma_oe_n    = dmaoe_q;
  assign port_irq_out     = irq_q;
  assign port_irq_oe_n    = irqoe_q;

endmodule : fpm_top

// file: sim/fpm_checker.sv
module fpm_checker (
  input logic       sys_clk,          // Clock
  input logic       sys_rst,          // Reset
  input logic [9:0] fdc_out,          // Core outputs
  input logic       fdc_drv_sel,      // Drive 1 chosen
  input logic [9:0] nat_oe_n,         // Native enables
  input logic [7:0] pd_out,           // Data pins
  input logic [7:0] pd_oe_n,          // Data enables
  input logic [8:0] pc_out,           // Ctrl pins
  input logic [8:0] pc_oe_n,          // Ctrl enables
  input logic       port_dma_request, // DMA pin
  input logic       port_dma_oe_n,    // DMA enable
  input logic       port_irq_out      // IRQ pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] f_q;         // Core outputs one cycle back, pins lag by one
  wire mx = !pc_oe_n[4];   // Ack pin is driven only while muxed
  wire dl = mx && !pd_oe_n[6];
  wire sg = mx && pd_oe_n[6];
  always_ff @(posedge sys_clk)
    f_q <= fdc_out;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_nat_float: assert property (dl |-> &nat_oe_n) else $error("native driven");
  a_sgl_native: assert property (sg && $past(sg) && !$past(fdc_drv_sel)
    |-> nat_oe_n == 10'h000) else $error("native off");
  a_ack_map: assert property (mx
    |-> pc_out[8:1] == {f_q[2], f_q[3], f_q[0], f_q[9], f_q[7], f_q[5], f_q[4], f_q[1]})
    else $error("pin map");
  a_dual_drive: assert property (dl
    |-> pc_out[0] == f_q[6] && pd_out[6] == f_q[8] && !pc_oe_n[0]) else $error("dual");
  a_sgl_input: assert property (sg |-> pc_oe_n[0]) else $error("strobe driven");
  a_dma_low: assert property (mx && !port_dma_oe_n |-> !port_dma_request) else $error("dma");
  a_irq_idle: assert property (mx |-> !port_irq_out) else $error("irq");
  a_port_off: assert property (mx |-> pd_oe_n[7] && pd_oe_n[5]) else $error("printer");
  c_dual: cover property (dl);
  c_sgl: cover property (sg && &nat_oe_n);
  c_dma: cover property (mx && !port_dma_oe_n);
endmodule : fpm_checker

// file: sim/fpm_drive_model.sv
module fpm_drive_model (
  input  logic       sys_clk, // Clock
  input  logic [4:0] stat,    // Drive status levels
  input  logic [7:0] pd_out,  // Data pins from block
  input  logic [7:0] pd_oe_n, // Data enables, low
  input  logic [8:0] pc_out,  // Ctrl pins from block
  input  logic [8:0] pc_oe_n, // Ctrl enables, low
  output logic [7:0] pd_in,   // Data pin levels
  output logic [8:0] pc_in    // Ctrl pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic t_q = 1'b0; // Floating lines wander so a stale level never passes
  always @(posedge sys_clk)
    t_q <= !t_q;
  // Drive status sits on data lines 0 to 4 whenever the block lets go
  assign pd_in = (pd_out & ~pd_oe_n) | ({{3{t_q}}, stat} & pd_oe_n);
  assign pc_in = (pc_out & ~pc_oe_n) | ({9{t_q}} & pc_oe_n);
endmodule : fpm_drive_model

// file: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fpm_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fdc_drv_sel = 1'b0;
  logic pp_dma_req = 1'b0, pp_irq = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, port_dma_request, port_dma_oe_n, port_irq_out;
  logic port_irq_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf;
  fpm_addr_t  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  fpm_data_t  s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [9:0] fdc_out = 10'h000, nat_out, nat_oe_n;
  logic [4:0] fdc_in, nat_in = 5'h00, drv_stat = 5'h00;
  logic [7:0] pd_in, pd_out, pd_oe_n;
  logic [8:0] pc_in, pc_out, pc_oe_n;
  int err_count = 0, checks = 0;
  fpm_top DUT (.*);
  fpm_drive_model drv (.sys_clk, .stat(drv_stat), .pd_out, .pd_oe_n, .pc_out, .pc_oe_n,
    .pd_in, .pc_in);
  initial
    forever #20 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input fpm_addr_t a, input fpm_data_t d);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input fpm_addr_t a);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_single;
    {fdc_out, nat_in} <= {10'h2b5, 5'h13};
    wr(8'h10, 32'h3b);
    wr(8'h08, 32'ha5);
    wr(8'h00, 32'h02);
    repeat (3) @(posedge sys_clk);
    chk(32'(nat_oe_n), 32'h0);
    chk(32'({nat_out, fdc_in}), 32'h56b3);
    chk(32'(pc_oe_n[0]), 32'h1);
    rd(8'h08);
    chk(v, 32'ha5);
    rd(8'h10);
    chk(v, 32'h34);
    rd(8'h0c);
    chk(v, 32'h48);
    fdc_drv_sel <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(nat_oe_n), 32'h3ff);
    rd(8'h14);
    chk(v, 32'h09);
    $display("single drive test done");
  endtask : t_single
  task automatic t_dual;
    {fdc_out, drv_stat, fdc_drv_sel} <= {10'h2b5, 5'h15, 1'b0};
    wr(8'h00, 32'h1c);
    repeat (5) @(posedge sys_clk);
    chk(32'(pc_out), 32'h17c);
    chk(32'({pc_oe_n[0], pd_oe_n[6], pd_out[6]}), 32'h0);
    chk(32'({port_dma_oe_n, port_dma_request, port_irq_oe_n}), 32'h1);
    chk(32'(fdc_in), 32'h15);
    chk(32'(nat_oe_n), 32'h3ff);
    {fdc_out, drv_stat} <= {10'h3f5, 5'h0a};
    wr(8'h00, 32'h2d);
    repeat (5) @(posedge sys_clk);
    chk(32'({port_dma_oe_n, port_irq_oe_n, port_irq_out}), 32'h4);
    chk(32'({fdc_in, pc_out}), 32'h157d);
    chk(32'(pd_out), 32'h40);
    rd(8'h14);
    chk(v, 32'h0b);
    $display("dual drive test done");
  endtask : t_dual
  task automatic t_normal;
    {pp_dma_req, pp_irq} <= 2'b11;
    wr(8'h00, 32'h01);
    rd(8'h14);
    chk(v, 32'h04);
    chk(32'({port_dma_oe_n, port_dma_request, port_irq_oe_n, port_irq_out}), 32'h5);
    wr(8'h00, 32'h00);
    rd(8'h14);
    chk(v, 32'h00);
    chk(32'({port_dma_oe_n, port_dma_request, port_irq_oe_n, port_irq_out}), 32'ha);
    wr(8'h0c, 32'h00);
    chk(32'(s_axi_bresp), 32'h2);
    rd(8'h20);
    chk(32'(s_axi_rresp), 32'h2);
    $display("normal mode test done");
  endtask : t_normal
  task automatic tally_and_finish;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_single;
    t_dual;
    t_normal;
    tally_and_finish;
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    tally_and_finish;
  end
endmodule : testbench
bind fpm_top fpm_checker chk_i (.*);
